// file: rtl/rwpm_top.sv
// Resume-well PM configuration and status register with AXI4-Lite access.
`timescale 1ns/1ps
`include "rwpm_cfg.svh"
module rwpm_top #(
   parameter int unsigned LEAD0 = `RWPM_CYC(`RWPM_LEAD0_US),
   parameter int unsigned LAG0 = `RWPM_CYC(`RWPM_LAG0_US),
   parameter int unsigned LEAD1 = `RWPM_CYC(`RWPM_LEAD1_US),
   parameter int unsigned LAG1 = `RWPM_CYC(`RWPM_LAG1_US),
   parameter int unsigned LEAD2 = `RWPM_CYC(`RWPM_LEAD2_US),
   parameter int unsigned LAG2 = `RWPM_CYC(`RWPM_LAG2_US),
   parameter int unsigned LEAD3 = `RWPM_CYC(`RWPM_LEAD3_US),
   parameter int unsigned LAG3 = `RWPM_CYC(`RWPM_LAG3_US)
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic sleep_req,
   input wire logic in_s0,
   input wire logic thermal_trip,
   input wire logic display_lid_state,
   input wire logic system_reset_button_n,
   input wire logic power_good,
   input wire logic usb_wake_req,
   input wire logic gigabit_mac_wake_req,
   output logic wake_request,
   output logic force_s5,
   output logic sleep_s3_n,
   output logic standby_gate_n
);
   // =========================================================
   // Pin synchronisation
   // =========================================================
   logic [5:0] pins_s;
   logic trip_s;
   logic lid_s;
   logic rstbtn_n_s;
   logic pgood_s;
   logic usb_s;
   logic mac_s;

   rwpm_sync #(.W(6), .INIT(6'h0C)) u_sync (
      .clk(sys_clk),
      .rst_n(resetn),
      .d({thermal_trip, display_lid_state, system_reset_button_n, power_good,
          usb_wake_req, gigabit_mac_wake_req}),
      .q(pins_s)
   );
   assign {trip_s, lid_s, rstbtn_n_s, pgood_s, usb_s, mac_s} = pins_s;

   // =========================================================
   // AXI4-Lite slave
   // =========================================================
   rwpm_pkg::rwpm_regs_t regs_q;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic aw_have_q;
   logic w_have_q;
   logic wr_fire;
   logic wr_hit;
   logic [31:0] wmask;
   logic [31:0] wr_val;
   logic pgood_prev_q;

   function automatic logic [31:0] strb_mask(input logic [3:0] s);
      strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
   endfunction : strb_mask

   function automatic logic is_reg(input logic [7:0] a);
      is_reg = ({a[7:2], 2'b00} == `RWPM_OFF_RESUME_PM_CONFIG);
   endfunction : is_reg

   function automatic logic [31:0] read_word(input rwpm_pkg::rwpm_regs_t r, input logic lid);
      logic [31:0] v;
      v = 32'h0000_0000;
      v[`RWPM_BIT_GATE_EN] = r.gate_en;
      v[`RWPM_BIT_TIMING_HI:`RWPM_BIT_TIMING_LO] = r.timing;
      v[`RWPM_BIT_WAKE_OK] = r.wake_ok;
      v[`RWPM_BIT_TRIP_STS] = r.trip_sts;
      v[`RWPM_BIT_TRIP_EN] = r.trip_en;
      v[`RWPM_BIT_LID] = lid;
      v[`RWPM_BIT_RST_SEEN] = r.rst_seen;
      v[`RWPM_BIT_PGOOD_FAIL] = r.pgood_fail;
      v[`RWPM_BIT_MEM_INIT] = r.mem_init;
      read_word = v;
   endfunction : read_word

   assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
   assign wr_hit = wr_fire && is_reg(awaddr_q);
   assign wmask = wr_hit ? (strb_mask(wstrb_q) & `RWPM_WRITABLE_MASK) : 32'h0000_0000;
   assign wr_val = wdata_q & wmask;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         s_axi_awready <= 1'b1;
         aw_have_q <= 1'b0;
         awaddr_q <= 8'h00;
      end else if (s_axi_awvalid && s_axi_awready) begin
         awaddr_q <= s_axi_awaddr;
         aw_have_q <= 1'b1;
         s_axi_awready <= 1'b0;
      end else if (wr_fire) begin
         aw_have_q <= 1'b0;
      end else if (!aw_have_q && !s_axi_bvalid) begin
         s_axi_awready <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         s_axi_wready <= 1'b1;
         w_have_q <= 1'b0;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         wdata_q <= s_axi_wdata;
         wstrb_q <= s_axi_wstrb;
         w_have_q <= 1'b1;
         s_axi_wready <= 1'b0;
      end else if (wr_fire) begin
         w_have_q <= 1'b0;
      end else if (!w_have_q && !s_axi_bvalid) begin
         s_axi_wready <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= is_reg(awaddr_q) ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Reads are answered one cycle after the address is taken.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= 2'h0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= is_reg(s_axi_araddr) ? read_word(regs_q, lid_s) : 32'h0000_0000;
         s_axi_rresp <= is_reg(s_axi_araddr) ? 2'h0 : 2'h2;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // =========================================================
   // Register bits
   // =========================================================
   // One process owns the whole register word, so each bit has a single driver.
   // Resume-well reset leaves the wake-source bit clear until firmware sets it.
   // Sticky status bits: a hardware set in the same cycle as a clear wins.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         regs_q <= '0;
      end else begin
         if (wmask[`RWPM_BIT_GATE_EN])
            regs_q.gate_en <= wr_val[`RWPM_BIT_GATE_EN];
         if (wmask[`RWPM_BIT_TIMING_LO])
            regs_q.timing[0] <= wr_val[`RWPM_BIT_TIMING_LO];
         if (wmask[`RWPM_BIT_TIMING_HI])
            regs_q.timing[1] <= wr_val[`RWPM_BIT_TIMING_HI];
         if (wmask[`RWPM_BIT_TRIP_EN])
            regs_q.trip_en <= wr_val[`RWPM_BIT_TRIP_EN];
         if (wmask[`RWPM_BIT_MEM_INIT])
            regs_q.mem_init <= wr_val[`RWPM_BIT_MEM_INIT];
         if (wmask[`RWPM_BIT_WAKE_OK])
            regs_q.wake_ok <= wr_val[`RWPM_BIT_WAKE_OK];
         if (in_s0 && trip_s && regs_q.trip_en)
            regs_q.trip_sts <= 1'b1;
         else if (wr_val[`RWPM_BIT_TRIP_STS])
            regs_q.trip_sts <= 1'b0;
         if (!rstbtn_n_s)
            regs_q.rst_seen <= 1'b1;
         else if (wr_val[`RWPM_BIT_RST_SEEN])
            regs_q.rst_seen <= 1'b0;
         if (in_s0 && pgood_prev_q && !pgood_s)
            regs_q.pgood_fail <= 1'b1;
         else if (wr_val[`RWPM_BIT_PGOOD_FAIL])
            regs_q.pgood_fail <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         pgood_prev_q <= 1'b1;
      end else begin
         pgood_prev_q <= pgood_s;
      end
   end

   // =========================================================
   // Thermal shutdown and wake gating
   // =========================================================
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         force_s5 <= 1'b0;
         wake_request <= 1'b0;
      end else begin
         force_s5 <= in_s0 && trip_s && regs_q.trip_en;
         wake_request <= regs_q.wake_ok && (usb_s || mac_s);
      end
   end

   // =========================================================
   // Standby gate sequencing
   // =========================================================
   rwpm_gate_timer #(
      .LEAD0(LEAD0), .LAG0(LAG0), .LEAD1(LEAD1), .LAG1(LAG1),
      .LEAD2(LEAD2), .LAG2(LAG2), .LEAD3(LEAD3), .LAG3(LAG3)
   ) u_gate (
      .clk(sys_clk),
      .rst_n(resetn),
      .enable(regs_q.gate_en),
      .timing(regs_q.timing),
      .sleep_req(sleep_req),
      .sleep_s3_n(sleep_s3_n),
      .standby_gate_n(standby_gate_n)
   );

   // =========================================================
   // Checks
   // =========================================================
   property p_wake_block;
      @(posedge sys_clk) disable iff (!resetn)
         !regs_q.wake_ok |=> !wake_request;
   endproperty
   a_wake_block: assert property (p_wake_block) else $error("wake passed while blocked");

   property p_trip_off;
      @(posedge sys_clk) disable iff (!resetn)
         !regs_q.trip_en |=> !force_s5;
   endproperty
   a_trip_off: assert property (p_trip_off) else $error("shutdown with trip disabled");

   property p_rst_seen;
      @(posedge sys_clk) disable iff (!resetn)
         !rstbtn_n_s |=> regs_q.rst_seen;
   endproperty
   a_rst_seen: assert property (p_rst_seen) else $error("button press not recorded");

   property p_pg_fail;
      @(posedge sys_clk) disable iff (!resetn)
         in_s0 && pgood_prev_q && !pgood_s |=> regs_q.pgood_fail;
   endproperty
   a_pg_fail: assert property (p_pg_fail) else $error("power-good loss not recorded");

   property p_pg_hold;
      @(posedge sys_clk) disable iff (!resetn)
         regs_q.pgood_fail && !wr_val[`RWPM_BIT_PGOOD_FAIL] |=> regs_q.pgood_fail;
   endproperty
   a_pg_hold: assert property (p_pg_hold) else $error("power-good flag lost");

   property p_trip_sts;
      @(posedge sys_clk) disable iff (!resetn)
         force_s5 |-> regs_q.trip_sts;
   endproperty
   a_trip_sts: assert property (p_trip_sts) else $error("trip without status");

   property p_gate_off;
      @(posedge sys_clk) disable iff (!resetn)
         !regs_q.gate_en && standby_gate_n && sleep_s3_n |=> standby_gate_n;
   endproperty
   a_gate_off: assert property (p_gate_off) else $error("gate moved while disabled");

   property p_reserved;
      @(posedge sys_clk) disable iff (!resetn)
         s_axi_rvalid |-> (s_axi_rdata & ~`RWPM_WRITABLE_MASK) == 32'h0000_0000;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bits read nonzero");
endmodule : rwpm_top

// file: rtl/rwpm_cfg.svh
// Offsets, field positions, reset values and timing counts of the resume-well PM register.
`ifndef RWPM_CFG_SVH
`define RWPM_CFG_SVH
`define RWPM_OFF_RESUME_PM_CONFIG 8'h04
`define RWPM_BIT_GATE_EN 13
`define RWPM_BIT_TIMING_HI 12
`define RWPM_BIT_TIMING_LO 11
`define RWPM_BIT_WAKE_OK 7
`define RWPM_BIT_TRIP_STS 6
`define RWPM_BIT_TRIP_EN 5
`define RWPM_BIT_LID 4
`define RWPM_BIT_RST_SEEN 2
`define RWPM_BIT_PGOOD_FAIL 1
`define RWPM_BIT_MEM_INIT 0
`define RWPM_WRITABLE_MASK 32'h0000_3FF7
`define RWPM_RESET_VALUE 32'h0000_0000
`define RWPM_CLK_MHZ 200
`define RWPM_LEAD0_US 31250
`define RWPM_LAG0_US 125000
`define RWPM_LEAD1_US 62500
`define RWPM_LAG1_US 250000
`define RWPM_LEAD2_US 125000
`define RWPM_LAG2_US 500000
`define RWPM_LEAD3_US 125000
`define RWPM_LAG3_US 500000
`define RWPM_CYC(us) ((us) * `RWPM_CLK_MHZ)
`endif

// file: rtl/rwpm_pkg.sv
// Types shared by the resume-well PM register block.
package rwpm_pkg;
   typedef struct packed {
      logic gate_en;
      logic [1:0] timing;
      logic wake_ok;
      logic trip_sts;
      logic trip_en;
      logic rst_seen;
      logic pgood_fail;
      logic mem_init;
   } rwpm_regs_t;

   typedef enum logic [1:0] {
      RWPM_AWAKE = 2'b00,
      RWPM_LEAD = 2'b01,
      RWPM_ASLEEP = 2'b11,
      RWPM_LAG = 2'b10
   } rwpm_gate_st_t;
endpackage : rwpm_pkg

// file: rtl/rwpm_sync.sv
// Two-flop synchroniser for a bundle of asynchronous pin levels.
`timescale 1ns/1ps
module rwpm_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= INIT;
         q <= INIT;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule : rwpm_sync

// file: rtl/rwpm_gate_timer.sv
// Standby gate sequencer: leads sleep entry and lags wake-up by programmed times.
`timescale 1ns/1ps
`include "rwpm_cfg.svh"
module rwpm_gate_timer #(
   parameter int unsigned LEAD0 = `RWPM_CYC(`RWPM_LEAD0_US),
   parameter int unsigned LAG0 = `RWPM_CYC(`RWPM_LAG0_US),
   parameter int unsigned LEAD1 = `RWPM_CYC(`RWPM_LEAD1_US),
   parameter int unsigned LAG1 = `RWPM_CYC(`RWPM_LAG1_US),
   parameter int unsigned LEAD2 = `RWPM_CYC(`RWPM_LEAD2_US),
   parameter int unsigned LAG2 = `RWPM_CYC(`RWPM_LAG2_US),
   parameter int unsigned LEAD3 = `RWPM_CYC(`RWPM_LEAD3_US),
   parameter int unsigned LAG3 = `RWPM_CYC(`RWPM_LAG3_US)
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic enable,
   input wire logic [1:0] timing,
   input wire logic sleep_req,
   output logic sleep_s3_n,
   output logic standby_gate_n
);
   rwpm_pkg::rwpm_gate_st_t st_q;
   logic [27:0] cnt_q;

   function automatic logic [27:0] lead_of(input logic [1:0] t);
      case (t)
         2'b00: lead_of = 28'(LEAD0);
         2'b01: lead_of = 28'(LEAD1);
         2'b10: lead_of = 28'(LEAD2);
         default: lead_of = 28'(LEAD3);
      endcase
   endfunction : lead_of

   function automatic logic [27:0] lag_of(input logic [1:0] t);
      case (t)
         2'b00: lag_of = 28'(LAG0);
         2'b01: lag_of = 28'(LAG1);
         2'b10: lag_of = 28'(LAG2);
         default: lag_of = 28'(LAG3);
      endcase
   endfunction : lag_of

   // Gate asserts (low) ahead of the sleep signal, then releases after wake by the lag.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= rwpm_pkg::RWPM_AWAKE;
         cnt_q <= 28'h0000000;
         sleep_s3_n <= 1'b1;
         standby_gate_n <= 1'b1;
      end else begin
         case (st_q)
            rwpm_pkg::RWPM_AWAKE: begin
               if (sleep_req) begin
                  if (enable) begin
                     st_q <= rwpm_pkg::RWPM_LEAD;
                     cnt_q <= lead_of(timing);
                     standby_gate_n <= 1'b0;
                  end else begin
                     st_q <= rwpm_pkg::RWPM_ASLEEP;
                     sleep_s3_n <= 1'b0;
                  end
               end
            end
            rwpm_pkg::RWPM_LEAD: begin
               if (cnt_q <= 28'h0000001) begin
                  st_q <= rwpm_pkg::RWPM_ASLEEP;
                  sleep_s3_n <= 1'b0;
               end else begin
                  cnt_q <= cnt_q - 28'h0000001;
               end
            end
            rwpm_pkg::RWPM_ASLEEP: begin
               if (!sleep_req) begin
                  sleep_s3_n <= 1'b1;
                  if (!standby_gate_n) begin
                     st_q <= rwpm_pkg::RWPM_LAG;
                     cnt_q <= lag_of(timing);
                  end else begin
                     st_q <= rwpm_pkg::RWPM_AWAKE;
                  end
               end
            end
            rwpm_pkg::RWPM_LAG: begin
               if (cnt_q <= 28'h0000001) begin
                  st_q <= rwpm_pkg::RWPM_AWAKE;
                  standby_gate_n <= 1'b1;
               end else begin
                  cnt_q <= cnt_q - 28'h0000001;
               end
            end
            default: begin
               st_q <= rwpm_pkg::RWPM_AWAKE;
               sleep_s3_n <= 1'b1;
               standby_gate_n <= 1'b1;
            end
         endcase
      end
   end
endmodule : rwpm_gate_timer

// file: bench/rwpm_board_model.sv
// Board-side model of the power-good monitor on the standby rail.
`timescale 1ns/1ps
module rwpm_board_model (
   input wire logic sys_clk,
   input wire logic standby_gate_n,
   input wire logic fail_req,
   output logic power_good
);
   // =====================================================================
   // Power-good monitor
   // =====================================================================
   // The rail is reported good unless the bench commands a supply failure.
   // The gate input is not used: the block being tested does not depend on it.
   initial power_good = 1'b1;
   always @(posedge sys_clk) begin
      power_good <= ~fail_req;
   end
endmodule : rwpm_board_model

// file: bench/tb.sv
// Self-checking bench for the resume-well PM register block.
`timescale 1ns/1ps
module tb;
   // =====================================================================
   // Signals and design
   // =====================================================================
   localparam int unsigned LD[4] = '{20, 24, 30, 32};
   localparam int unsigned LG[4] = '{40, 48, 60, 64};
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0000_0000;
   logic [3:0] wstrb = 4'hF;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic sleep_req = 1'b0, in_s0 = 1'b0, trip = 1'b0, lid = 1'b0, btn_n = 1'b1;
   logic usb_req = 1'b0, mac_req = 1'b0, fail_req = 1'b0, power_good;
   logic wake_request, force_s5, sleep_s3_n, standby_gate_n;
   int error_cnt = 0;
   int num_checks = 0;
   int cyc = 0;

   rwpm_top #(.LEAD0(LD[0]), .LAG0(LG[0]), .LEAD1(LD[1]), .LAG1(LG[1]),
      .LEAD2(LD[2]), .LAG2(LG[2]), .LEAD3(LD[3]), .LAG3(LG[3])) u_rwpm_top (
      .sys_clk(sys_clk), .resetn(resetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .sleep_req(sleep_req), .in_s0(in_s0), .thermal_trip(trip), .display_lid_state(lid),
      .system_reset_button_n(btn_n), .power_good(power_good), .usb_wake_req(usb_req),
      .gigabit_mac_wake_req(mac_req), .wake_request(wake_request), .force_s5(force_s5),
      .sleep_s3_n(sleep_s3_n), .standby_gate_n(standby_gate_n));

   rwpm_board_model u_rwpm_board_model (.sys_clk(sys_clk), .standby_gate_n(standby_gate_n),
      .fail_req(fail_req), .power_good(power_good));

   initial begin
      forever #2.5 sys_clk = ~sys_clk;
   end

   // =====================================================================
   // Timeout and verdict
   // =====================================================================
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt = error_cnt + 1;
         wrap_up();
      end
   end

   task automatic wrap_up();
      if (error_cnt == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : wrap_up

   // =====================================================================
   // Compare tasks
   // =====================================================================
   task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk32

   task automatic chk1(input string what, input logic exp, input logic got);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error %s expected %b seen %b", what, exp, got);
      end
   endtask : chk1

   // =====================================================================
   // Bus tasks
   // =====================================================================
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw_done, w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      @(posedge sys_clk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw_done && w_done)) begin
         @(posedge sys_clk);
         if (awvalid && awready) begin
            aw_done = 1'b1;
            awvalid <= 1'b0;
         end
         if (wvalid && wready) begin
            w_done = 1'b1;
            wvalid <= 1'b0;
         end
      end
      while (bvalid !== 1'b1) @(posedge sys_clk);
      bready <= 1'b0;
      chk32("bresp", {30'h0000_0000, er}, {30'h0000_0000, bresp});
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      @(posedge sys_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge sys_clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      while (rvalid !== 1'b1) @(posedge sys_clk);
      rready <= 1'b0;
      chk32("rdata", ed, rdata);
      chk32("rresp", {30'h0000_0000, er}, {30'h0000_0000, rresp});
   endtask : rd

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : tick

   // Measures lead from gate fall to sleep fall and lag from sleep rise to gate rise.
   task automatic gate_run(input logic [1:0] code);
      logic [31:0] n;
      wr(8'h04, 32'h0000_2000 | ({30'h0000_0000, code} << 11), 2'b00);
      sleep_req <= 1'b1;
      while (standby_gate_n !== 1'b0) @(posedge sys_clk);
      n = 32'h0000_0000;
      while (sleep_s3_n !== 1'b0) begin
         @(posedge sys_clk);
         n++;
      end
      chk32("lead cycles", LD[code], n);
      tick(5);
      sleep_req <= 1'b0;
      while (sleep_s3_n !== 1'b1) @(posedge sys_clk);
      n = 32'h0000_0000;
      while (standby_gate_n !== 1'b1) begin
         @(posedge sys_clk);
         n++;
      end
      chk32("lag cycles", LG[code], n);
   endtask : gate_run

   // =====================================================================
   // Test sequence
   // =====================================================================
   initial begin
      tick(12);
      resetn <= 1'b1;
      rd(8'h04, 32'h0000_0000, 2'b00);
      wr(8'h04, 32'hFFFF_FFFF, 2'b00);
      rd(8'h04, 32'h0000_38A1, 2'b00);
      wstrb <= 4'hE;
      wr(8'h04, 32'h0000_0000, 2'b00);
      wstrb <= 4'hF;
      rd(8'h04, 32'h0000_00A1, 2'b00);
      wr(8'h04, 32'h0000_0000, 2'b00);
      wr(8'h08, 32'hFFFF_FFFF, 2'b10);
      rd(8'h08, 32'h0000_0000, 2'b10);
      rd(8'h04, 32'h0000_0000, 2'b00);
      lid <= 1'b1;
      tick(5);
      rd(8'h04, 32'h0000_0010, 2'b00);
      lid <= 1'b0;
      tick(5);
      rd(8'h04, 32'h0000_0000, 2'b00);
      usb_req <= 1'b1;
      mac_req <= 1'b1;
      tick(6);
      chk1("wake_request", 1'b0, wake_request);
      usb_req <= 1'b0;
      wr(8'h04, 32'h0000_0080, 2'b00);
      tick(6);
      chk1("wake_request", 1'b1, wake_request);
      wr(8'h04, 32'h0000_0000, 2'b00);
      mac_req <= 1'b0;
      in_s0 <= 1'b1;
      trip <= 1'b1;
      tick(6);
      chk1("force_s5", 1'b0, force_s5);
      rd(8'h04, 32'h0000_0000, 2'b00);
      wr(8'h04, 32'h0000_0020, 2'b00);
      tick(6);
      chk1("force_s5", 1'b1, force_s5);
      rd(8'h04, 32'h0000_0060, 2'b00);
      trip <= 1'b0;
      tick(6);
      wr(8'h04, 32'h0000_0060, 2'b00);
      rd(8'h04, 32'h0000_0020, 2'b00);
      wr(8'h04, 32'h0000_0000, 2'b00);
      btn_n <= 1'b0;
      tick(4);
      btn_n <= 1'b1;
      tick(6);
      rd(8'h04, 32'h0000_0004, 2'b00);
      wr(8'h04, 32'h0000_0000, 2'b00);
      rd(8'h04, 32'h0000_0004, 2'b00);
      wr(8'h04, 32'h0000_0004, 2'b00);
      rd(8'h04, 32'h0000_0000, 2'b00);
      fail_req <= 1'b1;
      tick(8);
      fail_req <= 1'b0;
      tick(8);
      rd(8'h04, 32'h0000_0002, 2'b00);
      wr(8'h04, 32'h0000_0000, 2'b00);
      rd(8'h04, 32'h0000_0002, 2'b00);
      wr(8'h04, 32'h0000_0002, 2'b00);
      rd(8'h04, 32'h0000_0000, 2'b00);
      in_s0 <= 1'b0;
      fail_req <= 1'b1;
      tick(8);
      fail_req <= 1'b0;
      tick(8);
      rd(8'h04, 32'h0000_0000, 2'b00);
      wr(8'h04, 32'h0000_0001, 2'b00);
      rd(8'h04, 32'h0000_0001, 2'b00);
      wr(8'h04, 32'h0000_0000, 2'b00);
      wr(8'h04, 32'h0000_0080, 2'b00);
      resetn <= 1'b0;
      tick(3);
      resetn <= 1'b1;
      rd(8'h04, 32'h0000_0000, 2'b00);
      sleep_req <= 1'b1;
      tick(10);
      chk1("sleep_s3_n", 1'b0, sleep_s3_n);
      chk1("standby_gate_n", 1'b1, standby_gate_n);
      sleep_req <= 1'b0;
      tick(4);
      for (int c = 0; c < 4; c++) begin
         gate_run(c[1:0]);
      end
      wrap_up();
   end
endmodule : tb
